// [src/csi_pkg.sv]
/*
 * Shared constants for the contactor status indicator: lamp colour
 * encodings, blink timing, command timing and the register map.
 * Assumes a 250 MHz system clock; all counts derive from it.
 */
package csi_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ = 250;
	localparam int RELAY_HOLD_MS = 200;
	localparam int SHORT_CLOSE_MS = 500;
	localparam int REARM_BASE_MS = 60;
	localparam int RESTART_S = 6;
	localparam int FLASH_ON_MS = 250;
	localparam int FLASH_OFF_MS = 250;
	localparam int CODE_PAUSE_MS = 1000;
	localparam int DROPOUT_MS = 130;
	localparam int PICKUP_MS = 100;
	localparam int LONG_DROP_MS = 300;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int RELAY_HOLD_CYC = RELAY_HOLD_MS * MS_CYCLES;
	localparam int SHORT_CLOSE_CYC = SHORT_CLOSE_MS * MS_CYCLES;
	localparam int REARM_CYC = (REARM_BASE_MS + DROPOUT_MS) * MS_CYCLES;
	localparam int RESTART_CYC = RESTART_S * 1000 * MS_CYCLES;
	localparam int FLASH_ON_CYC = FLASH_ON_MS * MS_CYCLES;
	localparam int FLASH_OFF_CYC = FLASH_OFF_MS * MS_CYCLES;
	localparam int CODE_PAUSE_CYC = CODE_PAUSE_MS * MS_CYCLES;
	localparam int PICKUP_CYC = PICKUP_MS * MS_CYCLES;
	localparam int LONG_DROP_CYC = LONG_DROP_MS * MS_CYCLES;

	// ****************************************************************
	// Lamp colours
	// ****************************************************************
	typedef enum logic [1:0] {
		CSI_OFF = 2'h0,
		CSI_GREEN = 2'h1,
		CSI_YELLOW = 2'h2,
		CSI_RED = 2'h3
	} csi_colour_t;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CFG = 4'h8;
	localparam int CTRL_LATCH_BIT = 0;
	localparam int CFG_WIDTH = 12;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 12'h0_00;
	localparam logic [1:0] FLASH_NONE = 2'h0;

endpackage

// [src/csi_blinker.sv]
/*
 * Blink code generator: emits N red flashes then a pause, repeating.
 * Assumes code changes only between sequences do not matter; a new
 * code restarts the sequence at once.
 */
`timescale 1ns/100ps
`default_nettype none

module csi_blinker #(
	parameter int ON_CYC = csi_pkg::FLASH_ON_CYC,
	parameter int OFF_CYC = csi_pkg::FLASH_OFF_CYC,
	parameter int PAUSE_CYC = csi_pkg::CODE_PAUSE_CYC
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [1:0] code_in,
	output logic lit_out
);

	logic [31:0] timer;
	logic [1:0] count;
	logic lit;
	logic [1:0] last_code;

	// Flash sequencer; a code change restarts so counts never mix
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || code_in != last_code || code_in == 2'h0) begin
			timer <= 32'h0000_0000;
			count <= 2'h0;
			lit <= 1'b0;
		end else if (lit) begin
			if (timer >= 32'(ON_CYC - 1)) begin
				timer <= 32'h0000_0000;
				lit <= 1'b0;
				count <= count + 2'h1;
			end else begin
				timer <= timer + 32'h0000_0001;
			end
		end else if (count == code_in) begin
			if (timer >= 32'(PAUSE_CYC - 1)) begin
				timer <= 32'h0000_0000;
				count <= 2'h0;
				lit <= 1'b1;
			end else begin
				timer <= timer + 32'h0000_0001;
			end
		end else if (timer >= 32'(OFF_CYC - 1) || count == 2'h0) begin
			timer <= 32'h0000_0000;
			lit <= 1'b1;
		end else begin
			timer <= timer + 32'h0000_0001;
		end
	end

	// Code history for restart detection
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			last_code <= 2'h0;
		end else begin
			last_code <= code_in;
		end
	end

	assign lit_out = lit;

endmodule

`default_nettype wire

// [src/csi_top.sv]
/*
 * Contactor status indicator: module lamp and relay, contactor lamp
 * and relay, fault latching, warnings, restart delay and blink codes.
 * Assumes rstn_in is the power-up reset; commands, feedback and
 * supply flags are asynchronous pins, synchronised here.
 */
//
// Behaviour
// - Contactor lamp yellow from close until open
// - Contactor relay closed when closed or 200ms
// - Faults latch until power cycled
// - Close shorter than 500ms faults, red
// - Latched contactor stays closed, lamp yellow
// - Healthy open: green closed, off open
// - Healthy closed: green closed, yellow closed
// - Commands at power-up are invalid command
// - Latch trip failure: yellow open, yellow closed
// - Power-up closed: flash 2, yellow closed
// - Pickup failure: contactor flash 1
// - Drop-out during hold: contactor flash 2
// - Slow drop-out: contactor flash 3
// - Invalid config: module flash 1
// - Undervoltage with close: solid red
// - Blink codes: N flashes then pause
// - Warnings clear when command removed
// - Held contactor reclose ignored until restart timer expires
// - Latched close with trip is invalid
// - Held contactor close commands accepted at most every 6s
// - Close and jog act on rising edge only; trip acts on level
// - Switches sampled only at power-up
`timescale 1ns/100ps
`default_nettype none

module csi_top #(
	parameter int RELAY_HOLD_CYC = csi_pkg::RELAY_HOLD_CYC,
	parameter int SHORT_CLOSE_CYC = csi_pkg::SHORT_CLOSE_CYC,
	parameter int REARM_CYC = csi_pkg::REARM_CYC,
	parameter int RESTART_CYC = csi_pkg::RESTART_CYC,
	parameter int PICKUP_CYC = csi_pkg::PICKUP_CYC,
	parameter int LONG_DROP_CYC = csi_pkg::LONG_DROP_CYC,
	parameter int FLASH_ON_CYC = csi_pkg::FLASH_ON_CYC,
	parameter int FLASH_OFF_CYC = csi_pkg::FLASH_OFF_CYC,
	parameter int CODE_PAUSE_CYC = csi_pkg::CODE_PAUSE_CYC
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic close_cmd_in,
	input wire logic jog_cmd_in,
	input wire logic trip_cmd_in,
	input wire logic contactor_closed_in,
	input wire logic undervoltage_in,
	input wire logic [11:0] cfg_switch_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic [1:0] module_lamp_out,
	output logic module_relay_out,
	output logic [1:0] contactor_lamp_out,
	output logic contactor_relay_out,
	output logic coil_cmd_out
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [16:0] sync1;
	logic [16:0] sync2;
	logic close_s;
	logic jog_s;
	logic trip_s;
	logic fb_closed;
	logic uv;

	// Two stages; only sync2 is read downstream
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			sync1 <= 17'h0_0000;
			sync2 <= 17'h0_0000;
		end else begin
			sync1 <= {cfg_switch_in, undervoltage_in, contactor_closed_in,
				trip_cmd_in, jog_cmd_in, close_cmd_in};
			sync2 <= sync1;
		end
	end
	assign close_s = sync2[0];
	assign jog_s = sync2[1];
	assign trip_s = sync2[2];
	assign fb_closed = sync2[3];
	assign uv = sync2[4];

	// ****************************************************************
	// Power-up sampling and configuration
	// ****************************************************************
	logic [1:0] boot;
	logic [11:0] cfg;
	logic cfg_bad;
	logic mech_latch;
	logic latch_ctrl;
	logic boot_done;

	// Switches caught once after release; later changes ignored
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			boot <= 2'h0;
			cfg <= csi_pkg::CFG_RESET;
		end else if (boot != 2'h3) begin
			boot <= boot + 2'h1;
			if (boot == 2'h2) begin
				cfg <= sync2[16:5];
			end
		end
	end
	assign boot_done = (boot == 2'h3);
	// Reserved switch pattern stands for an unusable setup
	assign cfg_bad = (cfg[8:7] == 2'h3);
	assign mech_latch = latch_ctrl | (cfg[8:7] == 2'h2);

	// ****************************************************************
	// Command edges
	// ****************************************************************
	logic close_d;
	logic jog_d;
	logic close_rise;
	logic close_fall;
	logic jog_rise;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			close_d <= 1'b0;
			jog_d <= 1'b0;
		end else begin
			close_d <= close_s;
			jog_d <= jog_s;
		end
	end
	// Idle-level reset: no false fall; a held level rises before boot ends
	assign close_rise = close_s & ~close_d;
	assign close_fall = ~close_s & close_d;
	assign jog_rise = jog_s & ~jog_d;

	// ****************************************************************
	// Warnings
	// ****************************************************************
	logic warn_boot;
	logic warn_early;
	logic warn_combo;
	logic warn_trip_fail;
	logic [31:0] rearm_cnt;
	logic [31:0] trip_cnt;
	logic warn_any;

	// Commands present as power comes up; clear on removal
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			warn_boot <= 1'b0;
		end else if (boot == 2'h2 && (close_s | jog_s | trip_s)) begin
			warn_boot <= 1'b1;
		end else if (!(close_s | jog_s | trip_s)) begin
			warn_boot <= 1'b0;
		end
	end

	// Reclose inside the rearm window; host owes the wait
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			warn_early <= 1'b0;
		end else if ((close_rise | jog_rise) && rearm_cnt != 32'h0000_0000) begin
			warn_early <= 1'b1;
		end else if (!(close_s | jog_s)) begin
			warn_early <= 1'b0;
		end
	end

	// Close and trip together on a latched contactor
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			warn_combo <= 1'b0;
		end else begin
			warn_combo <= mech_latch & close_s & trip_s;
		end
	end

	// Trip asked but latched contactor stays closed
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			trip_cnt <= 32'h0000_0000;
			warn_trip_fail <= 1'b0;
		end else if (mech_latch && trip_s && fb_closed) begin
			if (trip_cnt >= 32'(LONG_DROP_CYC - 1)) begin
				warn_trip_fail <= 1'b1;
			end else begin
				trip_cnt <= trip_cnt + 32'h0000_0001;
			end
		end else begin
			trip_cnt <= 32'h0000_0000;
			if (!trip_s) begin
				warn_trip_fail <= 1'b0;
			end
		end
	end
	assign warn_any = warn_boot | warn_early | warn_combo;

	// ****************************************************************
	// Coil control and timers
	// ****************************************************************
	logic coil;
	logic jogging;
	logic [31:0] hold_cnt;
	logic [31:0] close_age;
	logic [31:0] restart_cnt;
	logic [31:0] drop_cnt;
	logic fault_any;
	logic start_ok;
	logic picked;

	// Held contactors obey the six second restart delay
	assign start_ok = boot_done & ~fault_any & ~warn_any & ~cfg_bad &
		(mech_latch | restart_cnt == 32'h0000_0000);

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			coil <= 1'b0;
			jogging <= 1'b0;
		end else if (fault_any || (uv && coil)) begin
			coil <= 1'b0;
			jogging <= 1'b0;
		end else if (close_rise && start_ok && !trip_s) begin
			coil <= 1'b1;
			jogging <= 1'b0;
		end else if (jog_rise && boot_done && !warn_any) begin
			coil <= 1'b1; // Jog bypasses restart delay
			jogging <= 1'b1;
		end else if (jogging && !jog_s) begin
			coil <= 1'b0;
			jogging <= 1'b0;
		end else if (mech_latch && trip_s) begin
			coil <= 1'b0;
		end else if (!mech_latch && !jogging && !close_s) begin
			coil <= 1'b0;
		end
	end
	// Latched contactor keeps its coil state without close held

	// Restart delay from each accepted close
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			restart_cnt <= 32'h0000_0000;
		end else if (close_rise && start_ok) begin
			restart_cnt <= 32'(RESTART_CYC);
		end else if (restart_cnt != 32'h0000_0000) begin
			restart_cnt <= restart_cnt - 32'h0000_0001;
		end
	end

	// Rearm window after a command is removed
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			rearm_cnt <= 32'h0000_0000;
		end else if (close_fall || (jog_d && !jog_s)) begin
			rearm_cnt <= 32'(REARM_CYC);
		end else if (rearm_cnt != 32'h0000_0000) begin
			rearm_cnt <= rearm_cnt - 32'h0000_0001;
		end
	end

	// Relay hold after a close command
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			hold_cnt <= 32'h0000_0000;
		end else if (close_rise && start_ok) begin
			hold_cnt <= 32'(RELAY_HOLD_CYC);
		end else if (hold_cnt != 32'h0000_0000) begin
			hold_cnt <= hold_cnt - 32'h0000_0001;
		end
	end

	// Age of the coil drive and time since it was dropped
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			close_age <= 32'h0000_0000;
			drop_cnt <= 32'h0000_0000;
			picked <= 1'b0;
		end else begin
			close_age <= coil ? close_age + 32'h0000_0001 : 32'h0000_0000;
			picked <= coil & (picked | fb_closed);
			drop_cnt <= (!coil && fb_closed) ? drop_cnt + 32'h0000_0001 :
				32'h0000_0000;
		end
	end

	// ****************************************************************
	// Latched faults
	// ****************************************************************
	logic f_pwr_closed;
	logic f_pickup;
	logic f_dropout;
	logic f_long_drop;
	logic f_short;
	logic f_uv;

	// Only a power-up reset clears these; no command path
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			f_pwr_closed <= 1'b0;
			f_pickup <= 1'b0;
			f_dropout <= 1'b0;
			f_long_drop <= 1'b0;
			f_short <= 1'b0;
			f_uv <= 1'b0;
		end else begin
			if (boot == 2'h2 && fb_closed) begin
				f_pwr_closed <= 1'b1;
			end
			// Never closed under this drive is pickup; closed then lost is drop
			if (coil && !picked && !fb_closed &&
				close_age >= 32'(PICKUP_CYC)) begin
				f_pickup <= 1'b1;
			end
			if (coil && !mech_latch && picked && !fb_closed) begin
				f_dropout <= 1'b1;
			end
			if (drop_cnt >= 32'(LONG_DROP_CYC) && !mech_latch) begin
				f_long_drop <= 1'b1;
			end
			if (close_fall && coil && !jogging &&
				close_age < 32'(SHORT_CLOSE_CYC)) begin
				f_short <= 1'b1;
			end
			if (uv && (close_s || coil)) begin
				f_uv <= 1'b1;
			end
		end
	end
	assign fault_any = f_pwr_closed | f_pickup | f_dropout | f_long_drop |
		f_short | f_uv | (boot_done & cfg_bad);

	// ****************************************************************
	// Lamps and relays
	// ****************************************************************
	logic [1:0] mod_code;
	logic [1:0] con_code;
	logic mod_lit;
	logic con_lit;

	assign mod_code = f_pwr_closed ? 2'h2 :
		((boot_done & cfg_bad) ? 2'h1 : csi_pkg::FLASH_NONE);
	assign con_code = f_long_drop ? 2'h3 : f_dropout ? 2'h2 :
		f_pickup ? 2'h1 : csi_pkg::FLASH_NONE;

	csi_blinker #(
		.ON_CYC(FLASH_ON_CYC),
		.OFF_CYC(FLASH_OFF_CYC),
		.PAUSE_CYC(CODE_PAUSE_CYC)
	) u_mod_blink (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.code_in(mod_code),
		.lit_out(mod_lit)
	);

	csi_blinker #(
		.ON_CYC(FLASH_ON_CYC),
		.OFF_CYC(FLASH_OFF_CYC),
		.PAUSE_CYC(CODE_PAUSE_CYC)
	) u_con_blink (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.code_in(con_code),
		.lit_out(con_lit)
	);

	// Outputs registered; priority fault, then warning, then healthy
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			module_lamp_out <= csi_pkg::CSI_OFF;
			module_relay_out <= 1'b0;
			contactor_lamp_out <= csi_pkg::CSI_OFF;
			contactor_relay_out <= 1'b0;
		end else if (mod_code != csi_pkg::FLASH_NONE) begin
			module_lamp_out <= mod_lit ? csi_pkg::CSI_RED : csi_pkg::CSI_OFF;
			module_relay_out <= 1'b0;
			contactor_lamp_out <= f_pwr_closed ? csi_pkg::CSI_YELLOW :
				csi_pkg::CSI_OFF;
			contactor_relay_out <= f_pwr_closed;
		end else if (con_code != csi_pkg::FLASH_NONE) begin
			module_lamp_out <= csi_pkg::CSI_GREEN;
			module_relay_out <= 1'b0;
			contactor_lamp_out <= con_lit ? csi_pkg::CSI_RED : csi_pkg::CSI_OFF;
			contactor_relay_out <= 1'b0;
		end else if (f_uv || f_short) begin
			module_lamp_out <= csi_pkg::CSI_RED;
			module_relay_out <= 1'b0;
			contactor_lamp_out <= csi_pkg::CSI_OFF;
			contactor_relay_out <= 1'b0;
		end else if (warn_trip_fail) begin
			module_lamp_out <= csi_pkg::CSI_YELLOW;
			module_relay_out <= 1'b0;
			contactor_lamp_out <= csi_pkg::CSI_YELLOW;
			contactor_relay_out <= 1'b1;
		end else if (warn_any) begin
			module_lamp_out <= csi_pkg::CSI_YELLOW;
			module_relay_out <= 1'b1;
			contactor_lamp_out <= csi_pkg::CSI_OFF;
			contactor_relay_out <= 1'b0;
		end else begin
			module_lamp_out <= boot_done ? csi_pkg::CSI_GREEN :
				csi_pkg::CSI_OFF;
			module_relay_out <= boot_done;
			contactor_lamp_out <= (coil && fb_closed) ? csi_pkg::CSI_YELLOW :
				csi_pkg::CSI_OFF;
			contactor_relay_out <= fb_closed ||
				hold_cnt != 32'h0000_0000;
		end
	end
	assign coil_cmd_out = coil;

	// ****************************************************************
	// Register port
	// ****************************************************************
	// Control: bit 0 forces latched-contactor handling
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			latch_ctrl <= 1'b0;
		end else if (wr_in && addr_in == csi_pkg::REG_CTRL) begin
			latch_ctrl <= wdata_in[csi_pkg::CTRL_LATCH_BIT];
		end
	end

	// Read data valid the cycle after the strobe; zero otherwise
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			case (addr_in)
				csi_pkg::REG_CTRL: rdata_out <= {31'h0000_0000, latch_ctrl};
				csi_pkg::REG_STATUS: rdata_out <= {20'h0_0000, warn_trip_fail,
					warn_combo, warn_early, warn_boot, f_uv, f_short,
					f_long_drop, f_dropout, f_pickup, f_pwr_closed,
					fb_closed, coil};
				csi_pkg::REG_CFG: rdata_out <= {20'h0_0000, cfg};
				default: rdata_out <= 32'h0000_0000;
			endcase
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// [verification/csi_contactor_model.sv]
/* Contactor mechanism model driven by the coil output.
   Assumes the bench sets the fault knobs between steps. */
`timescale 1ns/100ps
`default_nettype none
module csi_contactor_model (
	input wire logic mclk_in,
	input wire logic coil_in,
	input wire logic latched_in,
	input wire logic trip_in,
	input wire logic stuck_in,
	input wire logic drop_in,
	output logic closed_out
);
	// ******
	// Armature
	// ******
	logic [2:0] travel = 3'h0;
	logic want;
	// Latched mechanism holds itself closed until tripped
	always_comb begin
		want = latched_in ? (coil_in | closed_out) & ~trip_in : coil_in;
	end
	// Five cycles of travel; a stuck armature never arrives
	always_ff @(posedge mclk_in) begin
		if (drop_in) begin
			closed_out <= 1'b0;
			travel <= 3'h0;
		end else if (stuck_in || closed_out == want) begin
			travel <= 3'h0;
		end else if (travel == 3'h4) begin
			closed_out <= want;
			travel <= 3'h0;
		end else begin
			travel <= travel + 3'h1;
		end
	end
endmodule
`default_nettype wire

// [verification/csi_top_chk.sv]
/* Property checker bound to csi_top.
   Assumes the bench's shortened timing parameters. */
`timescale 1ns/100ps
`default_nettype none
module csi_top_chk #(
	parameter int FLASH_ON_CYC = 4
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic close_cmd_in,
	input wire logic jog_cmd_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic [1:0] module_lamp_out,
	input wire logic module_relay_out,
	input wire logic [1:0] contactor_lamp_out,
	input wire logic contactor_relay_out,
	input wire logic coil_cmd_out
);
	// ******
	// Properties
	// ******
	logic [7:0] red_run;
	// Length of the running red flash
	always_ff @(posedge mclk_in) begin
		if (contactor_lamp_out == csi_pkg::CSI_RED) begin
			red_run <= red_run + 8'h01;
		end else begin
			red_run <= 8'h00;
		end
	end
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	a_reset_clears_all: assert property ($rose(rstn_in) |->
		{module_lamp_out, module_relay_out, contactor_lamp_out,
		contactor_relay_out, coil_cmd_out} == 7'h00)
		else $error("outputs not cleared by reset");
	a_module_relay_ok: assert property (module_relay_out |->
		module_lamp_out inside {csi_pkg::CSI_GREEN, csi_pkg::CSI_YELLOW})
		else $error("module relay closed in a fault");
	a_cont_red_open: assert property (
		contactor_lamp_out == csi_pkg::CSI_RED |->
		!contactor_relay_out && !coil_cmd_out)
		else $error("contactor fault with relay or coil on");
	a_cont_fault_sticks: assert property (
		contactor_lamp_out == csi_pkg::CSI_RED |=> !coil_cmd_out [*8])
		else $error("coil driven after contactor fault");
	a_flash_timing: assert property (
		$fell(contactor_lamp_out == csi_pkg::CSI_RED) |->
		red_run == 8'(FLASH_ON_CYC) ##0
		(contactor_lamp_out == csi_pkg::CSI_OFF) [*4])
		else $error("flash on or off time wrong");
	a_relay_hold: assert property ($rose(coil_cmd_out) |=>
		contactor_relay_out [*8])
		else $error("contactor relay not held after close");
	a_coil_needs_cmd: assert property ($rose(coil_cmd_out) |->
		$past(close_cmd_in, 2) || $past(jog_cmd_in, 2))
		else $error("coil rose without a command");
	a_yellow_relay: assert property (
		contactor_lamp_out == csi_pkg::CSI_YELLOW |-> contactor_relay_out)
		else $error("yellow contactor lamp with open relay");
	a_rdata_idle: assert property (!$past(rd_in) |->
		rdata_out == 32'h0000_0000)
		else $error("read data outside read slot");
endmodule
bind csi_top csi_top_chk #(.FLASH_ON_CYC(FLASH_ON_CYC)) u_chk (
	.mclk_in(mclk_in),
	.rstn_in(rstn_in),
	.close_cmd_in(close_cmd_in),
	.jog_cmd_in(jog_cmd_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.module_lamp_out(module_lamp_out),
	.module_relay_out(module_relay_out),
	.contactor_lamp_out(contactor_lamp_out),
	.contactor_relay_out(contactor_relay_out),
	.coil_cmd_out(coil_cmd_out)
);
`default_nettype wire

// [verification/csi_top_tb_top.sv]
/* Self-checking bench for csi_top with a contactor model.
   Assumes shortened timing, set at the instance below. */
`timescale 1ns/100ps
`default_nettype none
module csi_top_tb_top;
	// ******
	// Bench
	// ******
	typedef struct {string nm; logic [31:0] m; logic [31:0] e;} csi_note_t;
	localparam csi_pkg::csi_colour_t OFF = csi_pkg::CSI_OFF;
	localparam csi_pkg::csi_colour_t GRN = csi_pkg::CSI_GREEN;
	localparam csi_pkg::csi_colour_t YEL = csi_pkg::CSI_YELLOW;
	localparam csi_pkg::csi_colour_t RED = csi_pkg::CSI_RED;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0, close_cmd_in = 1'b0, jog_cmd_in = 1'b0;
	logic trip_cmd_in = 1'b0, undervoltage_in = 1'b0, wr_in = 1'b0;
	logic rd_in = 1'b0, look = 1'b0, rd_seen = 1'b0, latched = 1'b0;
	logic stuck = 1'b0, drop = 1'b0, contactor_closed_in, coil_cmd_out;
	logic [11:0] cfg_switch_in = 12'h000;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0000_0000, rdata_out;
	logic [1:0] module_lamp_out, contactor_lamp_out;
	logic module_relay_out, contactor_relay_out;
	int n_fail = 0, samples_checked = 0, seed = 46;
	csi_note_t notes[$];
	localparam int HOLD_CYC = 20;
	localparam int FLASH_CYC = 4;
	csi_top #(.RELAY_HOLD_CYC(HOLD_CYC), .SHORT_CLOSE_CYC(50),
		.REARM_CYC(HOLD_CYC), .RESTART_CYC(100), .PICKUP_CYC(10),
		.LONG_DROP_CYC(30), .FLASH_ON_CYC(FLASH_CYC),
		.FLASH_OFF_CYC(FLASH_CYC), .CODE_PAUSE_CYC(3 * FLASH_CYC)) dut (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.close_cmd_in(close_cmd_in),
		.jog_cmd_in(jog_cmd_in),
		.trip_cmd_in(trip_cmd_in),
		.contactor_closed_in(contactor_closed_in),
		.undervoltage_in(undervoltage_in),
		.cfg_switch_in(cfg_switch_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.module_lamp_out(module_lamp_out),
		.module_relay_out(module_relay_out),
		.contactor_lamp_out(contactor_lamp_out),
		.contactor_relay_out(contactor_relay_out),
		.coil_cmd_out(coil_cmd_out)
	);
	csi_contactor_model mech (
		.mclk_in(mclk_in),
		.coil_in(coil_cmd_out),
		.latched_in(latched),
		.trip_in(trip_cmd_in),
		.stuck_in(stuck),
		.drop_in(drop),
		.closed_out(contactor_closed_in)
	);
	// Free-running 250 MHz clock
	initial begin
		forever #2 mclk_in = ~mclk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Lamp snapshot; a mask hides a blinking lamp's phase
	task automatic snap(input string nm, input csi_pkg::csi_colour_t ml,
		input logic mr, input csi_pkg::csi_colour_t cl, input logic cr,
		input logic [5:0] m = 6'h3f);
		notes.push_back('{nm, {26'h000_0000, m},
			{26'h000_0000, {ml, mr, cl, cr} & m}});
		look <= 1'b1;
		tick(1);
		look <= 1'b0;
		tick(1);
	endtask
	task automatic rd(input string nm, input logic [3:0] a,
		input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
		notes.push_back('{nm, m, e});
		addr_in <= a;
		rd_in <= 1'b1;
		tick(1);
		rd_in <= 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		tick(1);
		wr_in <= 1'b0;
	endtask
	// Power cycle: six cycles low, then time to boot
	task automatic power_up(input logic [11:0] cfg);
		rstn_in <= 1'b0;
		cfg_switch_in <= cfg;
		tick(6);
		rstn_in <= 1'b1;
		tick(8);
	endtask
	task automatic fin(input string nm);
		$display("test %s finished, %0d mismatches", nm, n_fail);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Oldest note is compared whenever a snapshot or read data shows up
	always @(posedge mclk_in) begin
		csi_note_t n;
		logic [31:0] seen;
		seen = look ? {26'h000_0000, module_lamp_out, module_relay_out,
			contactor_lamp_out, contactor_relay_out} : rdata_out;
		if (look || rd_seen) begin
			n = notes.pop_front();
			check(n.nm, seen & n.m, n.e);
		end
		rd_seen <= rd_in;
	end
	// Whole run is under a thousand cycles; this cuts a hang
	initial begin
		tick(20000);
		n_fail++;
		$display("[ERR] watchdog expected done seen hang");
		tally_and_finish();
	end
	// Scenarios, each from a fresh power cycle
	initial begin
		logic [11:0] cfg;
		cfg = 12'($random(seed));
		cfg[8:7] = 2'h1;
		power_up(cfg);
		snap("idle", GRN, 1, OFF, 0);
		cfg_switch_in <= ~cfg;
		rd("cfg", csi_pkg::REG_CFG, {20'h0_0000, cfg});
		rd("hole", 4'hc, 32'h0000_0000);
		wr(csi_pkg::REG_CTRL, 32'h0000_0001);
		rd("ctrl", csi_pkg::REG_CTRL, 32'h0000_0001);
		wr(csi_pkg::REG_CTRL, 32'h0000_0000);
		close_cmd_in <= 1'b1;
		tick(55);
		snap("held", GRN, 1, YEL, 1);
		close_cmd_in <= 1'b0;
		tick(30);
		snap("opened", GRN, 1, OFF, 0);
		close_cmd_in <= 1'b1;
		tick(6);
		snap("too soon", GRN, 1, OFF, 0);
		close_cmd_in <= 1'b0;
		tick(40);
		close_cmd_in <= 1'b1;
		tick(55);
		snap("reclose", GRN, 1, YEL, 1);
		close_cmd_in <= 1'b0;
		tick(3);
		close_cmd_in <= 1'b1;
		tick(8);
		snap("early", YEL, 1, OFF, 0);
		close_cmd_in <= 1'b0;
		tick(8);
		snap("cleared", GRN, 1, OFF, 0);
		fin("restart");
		power_up(cfg);
		close_cmd_in <= 1'b1;
		tick(20);
		close_cmd_in <= 1'b0;
		tick(10);
		snap("short", RED, 0, OFF, 0);
		close_cmd_in <= 1'b1;
		tick(30);
		snap("stays", RED, 0, OFF, 0);
		close_cmd_in <= 1'b0;
		power_up(cfg);
		stuck <= 1'b1;
		close_cmd_in <= 1'b1;
		tick(25);
		snap("no pickup", GRN, 0, OFF, 0, 6'h39);
		rd("pickup bit", csi_pkg::REG_STATUS, 32'h08, 32'h38);
		tick(40);
		close_cmd_in <= 1'b0;
		stuck <= 1'b0;
		power_up(cfg);
		close_cmd_in <= 1'b1;
		tick(30);
		drop <= 1'b1;
		tick(15);
		snap("dropped", GRN, 0, OFF, 0, 6'h39);
		rd("dropout bit", csi_pkg::REG_STATUS, 32'h10, 32'h38);
		{drop, close_cmd_in} <= 2'h0;
		power_up(cfg);
		close_cmd_in <= 1'b1;
		tick(55);
		{stuck, close_cmd_in} <= 2'h2;
		tick(45);
		snap("slow drop", GRN, 0, OFF, 0, 6'h39);
		rd("slow drop bit", csi_pkg::REG_STATUS, 32'h20, 32'h38);
		stuck <= 1'b0;
		power_up(cfg);
		close_cmd_in <= 1'b1;
		tick(30);
		undervoltage_in <= 1'b1;
		tick(10);
		snap("low supply", RED, 0, OFF, 0);
		{undervoltage_in, close_cmd_in} <= 2'h0;
		fin("faults");
		power_up({cfg[11:9], 2'h3, cfg[6:0]});
		snap("bad config", OFF, 0, OFF, 0, 6'h0f);
		for (int i = 0; i < 3; i++) begin
			{close_cmd_in, jog_cmd_in, trip_cmd_in} <= 3'h1 << i;
			power_up(cfg);
			snap("cmd at boot", YEL, 1, OFF, 0);
			{close_cmd_in, jog_cmd_in, trip_cmd_in} <= 3'h0;
			tick(8);
			snap("cmd gone", GRN, 1, OFF, 0);
		end
		cfg[8:7] = 2'h2;
		latched <= 1'b1;
		power_up(cfg);
		{close_cmd_in, trip_cmd_in} <= 2'h3;
		tick(10);
		snap("close and trip", YEL, 1, OFF, 0);
		{close_cmd_in, trip_cmd_in} <= 2'h0;
		tick(30);
		close_cmd_in <= 1'b1;
		tick(55);
		close_cmd_in <= 1'b0;
		tick(10);
		snap("latched on", GRN, 1, YEL, 1);
		{stuck, trip_cmd_in} <= 2'h3;
		tick(45);
		snap("trip fails", YEL, 0, YEL, 1);
		trip_cmd_in <= 1'b0;
		tick(5);
		power_up(cfg);
		snap("boot closed", OFF, 0, YEL, 1, 6'h0f);
		{stuck, latched} <= 2'h0;
		fin("latched");
		tally_and_finish();
	end
endmodule
`default_nettype wire
